// ===== pkg/charger_defs.svh
// Timing and current constants for the charger sequencer and input protection control.
`ifndef CHARGER_DEFS_SVH
`define CHARGER_DEFS_SVH
`define CLK_HZ 25000000
`define BLANK_MS 10
`define STARTUP_MS 10
`define FAULT_DELAY_NS 1000
`define TRICKLE_MIN 25
`define CC_HOURS 3
`define CV_HOURS 3
`define MS_CYCLES (`CLK_HZ / 1000)
`define TRICKLE_LIMIT_MS (`TRICKLE_MIN * 60 * 1000)
`define CC_LIMIT_MS (`CC_HOURS * 3600 * 1000)
`define CV_LIMIT_MS (`CV_HOURS * 3600 * 1000)
`define TRICKLE_PCT 10
`define FULL_PCT 100
`endif

// ===== pkg/charger_pkg.sv
// Charge state type used by the charger sequencer.
package charger_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_TRICKLE,
    ST_CC,
    ST_CV,
    ST_SLEEP,
    ST_TIMEOUT
  } charge_state_t;
endpackage

// ===== rtl/ms_tick.sv
// Divider that issues a one-cycle pulse each millisecond.
`timescale 1ns/1ps
`include "charger_defs.svh"
module ms_tick #(
  parameter int CYCLES = `MS_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Tick output.
  output logic tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } tick_state_t;

  tick_state_t s_q;
  tick_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt >= 32'(CYCLES - 1)) begin
      s_d.cnt = 32'h0000_0000;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule

// ===== rtl/charger_ctrl.sv
// Charge phase sequencer with input over-voltage protection control.
`timescale 1ns/1ps
`include "charger_defs.svh"
module charger_ctrl
  import charger_pkg::*;
#(
  parameter int TICK_CYCLES = `MS_CYCLES,
  parameter int BLANK_MS = `BLANK_MS,
  parameter int STARTUP_MS = `STARTUP_MS,
  parameter int TRICKLE_LIMIT_MS = `TRICKLE_LIMIT_MS,
  parameter int CC_LIMIT_MS = `CC_LIMIT_MS,
  parameter int CV_LIMIT_MS = `CV_LIMIT_MS
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Comparator flags from the analog side.
  input wire logic supply_above_lockout,
  input wire logic supply_above_lockout_hyst,
  input wire logic input_overvoltage,
  input wire logic bat_below_precond,
  input wire logic bat_at_regulation_point,
  input wire logic charge_at_term_current,
  input wire logic bat_below_recharge_threshold,
  // Enable pins.
  input wire logic charger_enable,
  input wire logic protect_stage_enable_low,
  // Protection switch and fault flag.
  output logic switch_on,
  output logic input_fault_flag_n_o,
  output logic input_fault_flag_n_oe,
  // Charger drive and status.
  output logic charge_on,
  output logic [6:0] current_target_pct,
  output logic status_led_on,
  output logic charge_timeout
);
  localparam int NSYNC = 9;

  typedef struct packed {
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic lockout_ok;
    logic fault;
    logic [31:0] blank_cnt;
    logic [31:0] start_cnt;
    logic started;
    logic sw;
    charge_state_t st;
    logic [31:0] phase_ms;
    logic chg;
    logic [6:0] pct;
    logic led;
    logic tmo;
  } ctrl_state_t;

  ctrl_state_t s_q;
  ctrl_state_t s_d;
  logic tick;
  logic [NSYNC-1:0] raw;
  logic lo_above;
  logic lo_hyst;
  logic ovp;
  logic precond_low;
  logic at_reg;
  logic at_term;
  logic below_rch;
  logic chg_en;
  logic prot_dis;
  logic supply_ok;

  ms_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .arst_n(arst_n),
    .tick(tick)
  );

  assign raw = {supply_above_lockout, supply_above_lockout_hyst,
    input_overvoltage, bat_below_precond, bat_at_regulation_point,
    charge_at_term_current, bat_below_recharge_threshold,
    charger_enable, protect_stage_enable_low};
  assign {lo_above, lo_hyst, ovp, precond_low, at_reg, at_term, below_rch,
    chg_en, prot_dis} = s_q.sync2;

  function automatic logic [31:0] count_ms(input logic [31:0] c,
                                           input logic t);
    count_ms = (t && c != 32'hFFFF_FFFF) ? c + 32'h0000_0001 : c;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.sync1 = raw;
    s_d.sync2 = s_q.sync1;
    if (!lo_above) begin
      s_d.lockout_ok = 1'b0;
    end else if (lo_hyst) begin
      s_d.lockout_ok = 1'b1;
    end
    supply_ok = s_q.lockout_ok && !ovp;
    // unfiltered fault set; blank before release.
    if (ovp) begin
      s_d.fault = 1'b1;
      s_d.blank_cnt = '0;
    end else if (s_q.fault) begin
      s_d.blank_cnt = count_ms(s_q.blank_cnt, tick);
      if (s_q.blank_cnt > 32'(BLANK_MS)) begin
        s_d.fault = 1'b0;
      end
    end
    if (!supply_ok || prot_dis) begin
      s_d.start_cnt = '0;
      s_d.started = 1'b0;
    end else if (!s_q.started) begin
      s_d.start_cnt = count_ms(s_q.start_cnt, tick);
      if (s_q.start_cnt > 32'(STARTUP_MS)) begin
        s_d.started = 1'b1;
      end
    end
    s_d.sw = supply_ok && !prot_dis && s_d.started;
    s_d.phase_ms = count_ms(s_q.phase_ms, tick);
    // charger held idle unless the switch is on and charger enable is high.
    if (!s_q.sw || !chg_en) begin
      s_d.st = ST_IDLE;
      s_d.phase_ms = '0;
    end else begin
      unique case (s_q.st)
        ST_IDLE: begin
          s_d.phase_ms = '0;
          s_d.st = precond_low ? ST_TRICKLE : ST_CC;
        end
        ST_TRICKLE: begin
          if (!precond_low) begin
            s_d.st = ST_CC;
          end else if (s_q.phase_ms >= 32'(TRICKLE_LIMIT_MS)) begin
            s_d.st = ST_TIMEOUT;
          end
        end
        ST_CC: begin
          // enter CV; timer restart and separate CV timeout.
          if (at_reg) begin
            s_d.st = ST_CV;
            s_d.phase_ms = '0;
          end else if (s_q.phase_ms >= 32'(CC_LIMIT_MS)) begin
            s_d.st = ST_TIMEOUT;
          end
        end
        ST_CV: begin
          if (at_term) begin
            s_d.st = ST_SLEEP;
          end else if (s_q.phase_ms >= 32'(CV_LIMIT_MS)) begin
            s_d.st = ST_TIMEOUT;
          end
        end
        ST_SLEEP: begin
          if (below_rch) begin
            s_d.st = ST_IDLE;
          end
        end
        ST_TIMEOUT: begin
          s_d.phase_ms = '0;
        end
      endcase
    end
    s_d.chg = (s_d.st == ST_TRICKLE) || (s_d.st == ST_CC) ||
              (s_d.st == ST_CV);
    s_d.pct = (s_d.st == ST_TRICKLE) ? 7'(`TRICKLE_PCT) :
              s_d.chg ? 7'(`FULL_PCT) : 7'h00;
    s_d.led = s_d.chg;
    s_d.tmo = (s_d.st == ST_TIMEOUT);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign switch_on = s_q.sw;
  assign input_fault_flag_n_o = 1'b0;
  assign input_fault_flag_n_oe = s_q.fault;
  assign charge_on = s_q.chg;
  assign current_target_pct = s_q.pct;
  assign status_led_on = s_q.led;
  assign charge_timeout = s_q.tmo;
endmodule

// ===== testbench/host_fault_model.sv
// Host side model of the pulled-up fault line.
`timescale 1ns/1ps
module host_fault_model (
  // Open-drain drive from the controller.
  input wire logic drive_o,
  input wire logic drive_oe,
  // Level seen by the host.
  output logic line_level
);
  assign line_level = drive_oe ? drive_o : 1'h1;
endmodule

// ===== testbench/charger_monitor.sv
// Port checker of the charger controller.
`timescale 1ns/1ps
module charger_monitor #(
  parameter int TICK_CYCLES = 4,
  parameter int BLANK_MS = 3,
  parameter int STARTUP_MS = 3
) (
  // Watched ports.
  input wire logic clk,
  input wire logic arst_n,
  input wire logic supply_above_lockout,
  input wire logic input_overvoltage,
  input wire logic protect_stage_enable_low,
  input wire logic switch_on,
  input wire logic input_fault_flag_n_o,
  input wire logic input_fault_flag_n_oe,
  input wire logic charge_on,
  input wire logic status_led_on
);
  logic [7:0] low_q;
  logic [7:0] ok_q;
  logic ok;
  assign ok = supply_above_lockout && !input_overvoltage &&
    !protect_stage_enable_low;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_q <= 8'h00;
      ok_q <= 8'h00;
    end else begin
      low_q <= input_overvoltage ? 8'h00 : low_q + 8'(!(&low_q));
      ok_q <= ok ? ok_q + 8'(!(&ok_q)) : 8'h00;
    end
  end
  sequence s_ov_rise;
    $rose(input_overvoltage);
  endsequence
  sequence s_ov_held;
    input_overvoltage [*4];
  endsequence
  a_fault_fast: assert property (
    s_ov_rise |-> ##[1:4] input_fault_flag_n_oe) else $error("late fault");
  a_ov_holds_open: assert property (
    s_ov_held |-> !switch_on && input_fault_flag_n_oe) else $error("ov on");
  a_lockout_open: assert property (
    (!supply_above_lockout) [*5] |-> !switch_on) else $error("lockout on");
  a_protect_open: assert property (
    protect_stage_enable_low [*4] |-> !switch_on) else $error("prot on");
  a_fault_drain: assert property (
    input_fault_flag_n_o == 1'h0) else $error("fault drive high");
  a_blank_hold: assert property (
    $fell(input_fault_flag_n_oe) |-> low_q >= BLANK_MS * TICK_CYCLES)
    else $error("blank short");
  a_startup_wait: assert property (
    $rose(switch_on) |-> ok_q >= STARTUP_MS * TICK_CYCLES)
    else $error("startup short");
  a_led_status: assert property (
    status_led_on == charge_on) else $error("led wrong");
endmodule
bind charger_ctrl charger_monitor #(.TICK_CYCLES(TICK_CYCLES),
  .BLANK_MS(BLANK_MS), .STARTUP_MS(STARTUP_MS)) mon_u (.clk(clk),
  .arst_n(arst_n), .supply_above_lockout(supply_above_lockout),
  .input_overvoltage(input_overvoltage),
  .protect_stage_enable_low(protect_stage_enable_low),
  .switch_on(switch_on), .input_fault_flag_n_o(input_fault_flag_n_o),
  .input_fault_flag_n_oe(input_fault_flag_n_oe), .charge_on(charge_on),
  .status_led_on(status_led_on));

// ===== testbench/testbench.sv
// Bench of the charger controller.
`timescale 1ns/1ps
module testbench;
  logic clk, arst_n, lk, lkh, ov, pre, rp, tm, rc, en, pe;
  logic sw, fo, foe, chg, led, tmo, line;
  logic [6:0] pct;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  charger_ctrl #(.TICK_CYCLES(4), .BLANK_MS(3), .STARTUP_MS(3),
    .TRICKLE_LIMIT_MS(20), .CC_LIMIT_MS(40)) dut_u (
    .clk(clk), .arst_n(arst_n), .supply_above_lockout(lk),
    .supply_above_lockout_hyst(lkh), .input_overvoltage(ov),
    .bat_below_precond(pre), .bat_at_regulation_point(rp),
    .charge_at_term_current(tm), .bat_below_recharge_threshold(rc),
    .charger_enable(en), .protect_stage_enable_low(pe), .switch_on(sw),
    .input_fault_flag_n_o(fo), .input_fault_flag_n_oe(foe),
    .charge_on(chg), .current_target_pct(pct), .status_led_on(led),
    .charge_timeout(tmo));
  host_fault_model host_u (.drive_o(fo), .drive_oe(foe), .line_level(line));
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [6:0] got, input logic [6:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_sw();
    for (int i = 0; i < 60 && sw !== 1'h1; i++) w(1);
    chk(sw, 1'h1);
  endtask
  task automatic t_charge();
    en = 1'h1;
    pre = 1'h1;
    w(8);
    chk(pct, 7'h0a);
    chk(led, 1'h1);
    pre = 1'h0;
    w(6);
    chk(pct, 7'h64);
    rp = 1'h1;
    w(6);
    chk(chg, 1'h1);
    tm = 1'h1;
    w(6);
    chk(led, 1'h0);
    rp = 1'h0;
    tm = 1'h0;
    w(6);
    chk(chg, 1'h0);
    rc = 1'h1;
    w(8);
    chk(chg, 1'h1);
    rc = 1'h0;
    en = 1'h0;
    w(6);
    chk(chg, 1'h0);
    chk(sw, 1'h1);
  endtask
  task automatic t_timeout();
    en = 1'h1;
    pre = 1'h1;
    w(110);
    chk(tmo, 1'h1);
    chk(chg, 1'h0);
    en = 1'h0;
    pre = 1'h0;
    w(6);
    chk(tmo, 1'h0);
  endtask
  task automatic t_ovp();
    en = 1'h1;
    w(8);
    ov = 1'h1;
    w(4);
    chk(line, 1'h0);
    chk(sw, 1'h0);
    chk(chg, 1'h0);
    pe = 1'h1;
    w(4);
    pe = 1'h0;
    w(4);
    chk(sw, 1'h0);
    ov = 1'h0;
    w(12);
    chk(line, 1'h0);
    w(30);
    chk(line, 1'h1);
    wait_sw();
    en = 1'h0;
  endtask
  task automatic t_protect();
    pe = 1'h1;
    w(4);
    chk(sw, 1'h0);
    pe = 1'h0;
    wait_sw();
    lk = 1'h0;
    lkh = 1'h0;
    w(4);
    chk(sw, 1'h0);
    lk = 1'h1;
    w(30);
    chk(sw, 1'h0);
    lkh = 1'h1;
    wait_sw();
  endtask
  initial begin
    {arst_n, lk, lkh, ov, pre, rp, tm, rc, en, pe} = 10'h000;
    w(10);
    arst_n = 1'h1;
    lk = 1'h1;
    lkh = 1'h1;
    wait_sw();
    t_charge();
    t_timeout();
    t_ovp();
    t_protect();
    report_and_stop();
  end
endmodule
